// ==== rtl/prc_command_map.sv ====
// command register map of a digital rail controller with on/off timing
// assumes a host-side framer that presents one decoded command per strobe
`timescale 1ns/1ps
module prc_command_map #(
	parameter int CYCLES_PER_MS = prc_pkg::CYCLES_PER_MS
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] cmd_code,
	input wire logic wr_strobe,
	input wire logic [15:0] wr_data,
	input wire logic rd_strobe,
	output logic [15:0] rd_data,
	output logic rd_valid,
	input wire logic clear_faults,
	input wire logic [7:0] vout_flag_set,
	input wire logic [7:0] iout_flag_set,
	input wire logic [7:0] input_flag_set,
	input wire logic [7:0] temp_flag_set,
	input wire logic [7:0] cml_flag_set,
	input wire logic [7:0] mfr_flag_set,
	input wire logic telemetry_load,
	input wire logic [15:0] vin_sample,
	input wire logic [15:0] iin_sample,
	input wire logic [15:0] vout_sample,
	input wire logic [15:0] iout_sample,
	input wire logic [15:0] temp_sample,
	input wire logic [15:0] vin_uv_fault_strap,
	input wire logic [15:0] vout_nominal_strap,
	input wire logic enable,
	output logic rail_on_delay,
	output logic rail_rising,
	output logic rail_on,
	output logic rail_off_delay,
	output logic rail_falling,
	output logic power_good,
	output logic fault_present
);

	function automatic logic [5:0] rw_lookup(input logic [7:0] code);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 0; i < prc_pkg::NUM_RW; i++) begin
			if (prc_pkg::RW_CODE[i] == code) r = {1'b1, 5'(i)};
		end
		return r;
	endfunction

	function automatic logic [3:0] st_lookup(input logic [7:0] code);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < prc_pkg::NUM_ST; i++) begin
			if (prc_pkg::ST_CODE[i] == code) r = {1'b1, 3'(i)};
		end
		return r;
	endfunction

	function automatic logic [3:0] tel_lookup(input logic [7:0] code);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < prc_pkg::NUM_TEL; i++) begin
			if (prc_pkg::TEL_CODE[i] == code) r = {1'b1, 3'(i)};
		end
		return r;
	endfunction

	// linear-11 milliseconds to clock cycles; negative times count as zero
	function automatic logic [39:0] l11_cycles(input logic [15:0] v);
		logic signed [5:0] e;
		logic [39:0] base;
		e = {v[15], v[15:11]};
		base = 40'(v[9:0]) * 40'(CYCLES_PER_MS);
		if (v[10]) return 40'h0;
		if (e < 0) return base >> 6'(-e);
		return base << 6'(e);
	endfunction

	logic [15:0] rw_q [prc_pkg::NUM_RW];
	logic [7:0] status_q [prc_pkg::NUM_ST];
	logic [7:0] flag_set [prc_pkg::NUM_ST];
	logic [15:0] tel_q [prc_pkg::NUM_TEL];
	logic straps_loaded;
	prc_pkg::prc_state_e state;
	prc_pkg::prc_state_e next_state;
	logic [39:0] cnt;
	logic [39:0] target;

	// command decode
	wire [5:0] rw_dec = rw_lookup(cmd_code);
	wire [3:0] st_dec = st_lookup(cmd_code);
	wire [3:0] tel_dec = tel_lookup(cmd_code);
	wire rw_hit = rw_dec[5];
	wire st_hit = st_dec[3];
	wire tel_hit = tel_dec[3];
	wire sum_byte_hit = cmd_code == prc_pkg::CODE_SUM_BYTE;
	wire sum_word_hit = cmd_code == prc_pkg::CODE_SUM_WORD;
	wire ro_hit = st_hit | tel_hit | sum_byte_hit | sum_word_hit;
	wire wr_rw = wr_strobe & rw_hit;
	wire wr_ro = wr_strobe & ro_hit;
	wire bad_cmd = (wr_strobe | rd_strobe) & ~rw_hit & ~ro_hit;

	// strap-derived defaults
	wire signed [14:0] uv_mant = 15'(signed'(vin_uv_fault_strap[10:0]));
	wire signed [14:0] uv_prod = uv_mant * signed'(15'(prc_pkg::UVW_NUM))
		/ signed'(15'(prc_pkg::UVW_DEN));
	wire uv_hi = uv_prod > signed'(15'(prc_pkg::L11_MANT_MAX));
	wire uv_lo = uv_prod < signed'(15'(prc_pkg::L11_MANT_MIN));
	wire [10:0] uv_sat = uv_hi ? 11'h3ff : uv_lo ? 11'h400 : uv_prod[10:0];
	wire [15:0] uv_warn_dflt = {vin_uv_fault_strap[15:11], uv_sat};
	wire [19:0] pg_prod = 20'(vout_nominal_strap) * 20'(prc_pkg::PG_NUM)
		/ 20'(prc_pkg::PG_DEN);
	wire [15:0] pg_dflt = pg_prod[15:0];

	always_ff @(posedge core_clk) begin
		if (rst) straps_loaded <= 1'b0;
		else straps_loaded <= 1'b1;
	end

	// read/write limits, actions and timing
	for (genvar g = 0; g < prc_pkg::NUM_RW; g++) begin : g_rw
		logic [15:0] strap_val;
		logic [15:0] wr_val;
		logic [15:0] next_rw;
		assign strap_val = (g == prc_pkg::IDX_UV_WARN) ? uv_warn_dflt :
			(g == prc_pkg::IDX_UV_FAULT) ? vin_uv_fault_strap : pg_dflt;
		assign wr_val = prc_pkg::RW_BYTE[g] ? {8'h00, wr_data[7:0]} : wr_data;
		wire is_strap = g == prc_pkg::IDX_UV_WARN ||
			g == prc_pkg::IDX_UV_FAULT || g == prc_pkg::IDX_PG;
		assign next_rw = (is_strap && !straps_loaded) ? strap_val :
			(wr_rw && rw_dec[4:0] == 5'(g)) ? wr_val : rw_q[g];
		always_ff @(posedge core_clk) begin
			if (rst) rw_q[g] <= prc_pkg::RW_RESET[g];
			else rw_q[g] <= next_rw;
		end
	end

	// sticky status flags; a set in the clearing cycle survives
	assign flag_set[prc_pkg::ST_VOUT] = vout_flag_set;
	assign flag_set[prc_pkg::ST_IOUT] = iout_flag_set;
	assign flag_set[prc_pkg::ST_INPUT] = input_flag_set;
	assign flag_set[prc_pkg::ST_TEMP] = temp_flag_set;
	assign flag_set[prc_pkg::ST_MFR] = mfr_flag_set;
	assign flag_set[prc_pkg::ST_CML] = cml_flag_set
		| (8'(wr_ro) << prc_pkg::CML_OTHER_COMM)
		| (8'(bad_cmd) << prc_pkg::CML_BAD_CMD);

	for (genvar g = 0; g < prc_pkg::NUM_ST; g++) begin : g_st
		wire [7:0] next_status = (clear_faults ? 8'h00 : status_q[g])
			| flag_set[g];
		always_ff @(posedge core_clk) begin
			if (rst) status_q[g] <= 8'h00;
			else status_q[g] <= next_status;
		end
	end

	// fault summary word, zero whenever every flag register is zero
	logic [15:0] sum_word;
	wire any_vout = |status_q[prc_pkg::ST_VOUT];
	wire any_iout = |status_q[prc_pkg::ST_IOUT];
	wire any_input = |status_q[prc_pkg::ST_INPUT];
	wire any_mfr = |status_q[prc_pkg::ST_MFR];
	always_comb begin
		sum_word = 16'h0000;
		sum_word[prc_pkg::WB_VOUT] = any_vout;
		sum_word[prc_pkg::WB_IOUT] = any_iout;
		sum_word[prc_pkg::WB_INPUT] = any_input;
		sum_word[prc_pkg::WB_MFR] = any_mfr;
		sum_word[prc_pkg::WB_TEMP] = |status_q[prc_pkg::ST_TEMP];
		sum_word[prc_pkg::WB_CML] = |status_q[prc_pkg::ST_CML];
		sum_word[prc_pkg::WB_OTHER] = any_vout | any_iout | any_input
			| any_mfr;
	end

	// telemetry captured on each load strobe
	for (genvar g = 0; g < prc_pkg::NUM_TEL; g++) begin : g_tel
		wire [15:0] sample = (g == 0) ? vin_sample : (g == 1) ? iin_sample :
			(g == 2) ? vout_sample : (g == 3) ? iout_sample : temp_sample;
		always_ff @(posedge core_clk) begin
			if (rst) tel_q[g] <= 16'h0000;
			else if (telemetry_load) tel_q[g] <= sample;
		end
	end

	// read path: data one cycle after the strobe
	wire [15:0] rd_mux =
		sum_byte_hit ? {8'h00, sum_word[7:0]} :
		sum_word_hit ? sum_word :
		st_hit ? {8'h00, status_q[st_dec[2:0]]} :
		tel_hit ? tel_q[tel_dec[2:0]] :
		rw_hit ? rw_q[rw_dec[4:0]] : 16'h0000;

	always_ff @(posedge core_clk) begin
		if (rst) rd_data <= 16'h0000;
		else if (rd_strobe) rd_data <= rd_mux;
	end

	always_ff @(posedge core_clk) begin
		if (rst) rd_valid <= 1'b0;
		else rd_valid <= rd_strobe;
	end

	// rail on/off sequencing
	wire done = (cnt + 40'h1) >= target;

	always_comb begin
		case (state)
			prc_pkg::ST_ON_DLY:
				target = l11_cycles(rw_q[prc_pkg::IDX_TON_DLY]);
			prc_pkg::ST_RISE:
				target = l11_cycles(rw_q[prc_pkg::IDX_TURN_ON_RAMP_TIME]);
			prc_pkg::ST_OFF_DLY:
				target = l11_cycles(rw_q[prc_pkg::IDX_TOFF_DLY]);
			prc_pkg::ST_FALL:
				target = l11_cycles(rw_q[prc_pkg::IDX_TURN_OFF_RAMP_TIME]);
			default: target = 40'h0;
		endcase
	end

	always_comb begin
		next_state = state;
		case (state)
			prc_pkg::ST_OFF: begin
				if (enable) next_state = prc_pkg::ST_ON_DLY;
			end
			prc_pkg::ST_ON_DLY: begin
				if (!enable) next_state = prc_pkg::ST_OFF;
				else if (done) next_state = prc_pkg::ST_RISE;
			end
			prc_pkg::ST_RISE: begin
				if (!enable) next_state = prc_pkg::ST_OFF_DLY;
				else if (done) next_state = prc_pkg::ST_ON;
			end
			prc_pkg::ST_ON: begin
				if (!enable) next_state = prc_pkg::ST_OFF_DLY;
			end
			prc_pkg::ST_OFF_DLY: begin
				if (enable) next_state = prc_pkg::ST_ON;
				else if (done) next_state = prc_pkg::ST_FALL;
			end
			prc_pkg::ST_FALL: begin
				if (enable) next_state = prc_pkg::ST_ON_DLY;
				else if (done) next_state = prc_pkg::ST_OFF;
			end
			default: next_state = prc_pkg::ST_OFF;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) state <= prc_pkg::ST_OFF;
		else state <= next_state;
	end

	always_ff @(posedge core_clk) begin
		if (rst || next_state != state) cnt <= 40'h0;
		else cnt <= cnt + 40'h1;
	end

	assign rail_on_delay = state == prc_pkg::ST_ON_DLY;
	assign rail_rising = state == prc_pkg::ST_RISE;
	assign rail_on = state == prc_pkg::ST_ON;
	assign rail_off_delay = state == prc_pkg::ST_OFF_DLY;
	assign rail_falling = state == prc_pkg::ST_FALL;

	wire pg_next = (state == prc_pkg::ST_ON) &&
		(tel_q[prc_pkg::TEL_VOUT] >= rw_q[prc_pkg::IDX_PG]);

	always_ff @(posedge core_clk) begin
		if (rst) power_good <= 1'b0;
		else power_good <= pg_next;
	end

	always_ff @(posedge core_clk) begin
		if (rst) fault_present <= 1'b0;
		else fault_present <= |sum_word;
	end

endmodule

// ==== rtl/prc_pkg.sv ====
// constants for the power rail command map
// assumes a 125 MHz core clock and 16-bit command data
package prc_pkg;
	localparam int NUM_RW = 18;
	localparam int NUM_ST = 6;
	localparam int NUM_TEL = 5;
	localparam logic [7:0] RW_CODE [NUM_RW] = '{
		8'h4b, 8'h4f, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56,
		8'h57, 8'h58, 8'h59, 8'h5a, 8'h5e, 8'h60, 8'h61, 8'h64, 8'h65};
	// strap-derived entries hold zero here and load after reset
	localparam logic [15:0] RW_RESET [NUM_RW] = '{
		16'hd440, 16'hebe8, 16'h0080, 16'heb70, 16'hdc40, 16'he530,
		16'h0080, 16'hd380, 16'h0080, 16'hd360, 16'h0000, 16'h0000,
		16'h0080, 16'h0000, 16'hca80, 16'hca80, 16'hca80, 16'hca80};
	localparam logic RW_BYTE [NUM_RW] = '{
		1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1,
		1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
	localparam int IDX_UV_WARN = 10;
	localparam int IDX_UV_FAULT = 11;
	localparam int IDX_PG = 13;
	localparam int IDX_TON_DLY = 14;
	localparam int IDX_TURN_ON_RAMP_TIME = 15;
	localparam int IDX_TOFF_DLY = 16;
	localparam int IDX_TURN_OFF_RAMP_TIME = 17;
	localparam logic [7:0] CODE_SUM_BYTE = 8'h78;
	localparam logic [7:0] CODE_SUM_WORD = 8'h79;
	localparam logic [7:0] ST_CODE [NUM_ST] = '{
		8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h80};
	localparam int ST_VOUT = 0;
	localparam int ST_IOUT = 1;
	localparam int ST_INPUT = 2;
	localparam int ST_TEMP = 3;
	localparam int ST_CML = 4;
	localparam int ST_MFR = 5;
	localparam logic [7:0] TEL_CODE [NUM_TEL] = '{
		8'h88, 8'h89, 8'h8b, 8'h8c, 8'h8d};
	localparam int TEL_VOUT = 2;
	localparam int CML_BAD_CMD = 7;
	localparam int CML_OTHER_COMM = 1;
	localparam int WB_VOUT = 15;
	localparam int WB_IOUT = 14;
	localparam int WB_INPUT = 13;
	localparam int WB_MFR = 12;
	localparam int WB_TEMP = 2;
	localparam int WB_CML = 1;
	localparam int WB_OTHER = 0;
	localparam int UVW_NUM = 11;
	localparam int UVW_DEN = 10;
	localparam int PG_NUM = 9;
	localparam int PG_DEN = 10;
	localparam int L11_MANT_MAX = 1023;
	localparam int L11_MANT_MIN = -1024;
	localparam int CLK_PERIOD_PS = 8000;
	localparam int MS_PS = 1000000000;
	localparam int CYCLES_PER_MS = MS_PS / CLK_PERIOD_PS;
	typedef enum logic [5:0] {
		ST_OFF = 6'b00_0001,
		ST_ON_DLY = 6'b00_0010,
		ST_RISE = 6'b00_0100,
		ST_ON = 6'b00_1000,
		ST_OFF_DLY = 6'b01_0000,
		ST_FALL = 6'b10_0000
	} prc_state_e;
endpackage

// ==== test/prc_command_map_asserts.sv ====
// port-level checks of the command map and the rail sequencer
// assumes the timing registers keep their 5 ms defaults while sequencing
`timescale 1ns/1ps
module prc_command_map_asserts #(
	parameter int CYCLES_PER_MS = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic rd_strobe,
	input wire logic rd_valid,
	input wire logic [7:0] vout_flag_set,
	input wire logic [7:0] iout_flag_set,
	input wire logic [7:0] input_flag_set,
	input wire logic [7:0] temp_flag_set,
	input wire logic [7:0] cml_flag_set,
	input wire logic [7:0] mfr_flag_set,
	input wire logic enable,
	input wire logic rail_on_delay,
	input wire logic rail_rising,
	input wire logic rail_on,
	input wire logic rail_off_delay,
	input wire logic rail_falling,
	input wire logic power_good,
	input wire logic fault_present
);
	localparam int T = 5 * CYCLES_PER_MS;
	logic [4:0] st;
	logic [4:0] prev_st;
	int cnt;
	assign st = {rail_falling, rail_off_delay, rail_on, rail_rising,
		rail_on_delay};
	// cnt holds the number of cycles spent in prev_st when st changes
	always_ff @(posedge core_clk) begin
		prev_st <= st;
		cnt <= (rst || st != prev_st) ? 1 : cnt + 1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_read_answer: assert property (1 |=> rd_valid == $past(rd_strobe))
		else $error("read answer missing or spurious");
	a_fault_summary: assert property ((|{vout_flag_set, iout_flag_set,
		input_flag_set, temp_flag_set, cml_flag_set, mfr_flag_set})
		|-> ##2 fault_present) else $error("fault not summarised");
	a_good_needs_on: assert property (!rail_on |=> !power_good)
		else $error("power good outside on state");
	a_seq_onehot: assert property ($onehot0(st))
		else $error("sequencer state not one-hot");
	a_seq_start: assert property ($rose(enable) && st == 5'h00
		|=> st == 5'h01) else $error("enable did not start delay");
	a_on_delay_len: assert property (prev_st == 5'h01 && st == 5'h02
		|-> cnt == T) else $error("turn-on delay length wrong");
	a_rise_len: assert property (prev_st == 5'h02 && st == 5'h04
		|-> cnt == T) else $error("rise length wrong");
	a_off_delay_len: assert property (prev_st == 5'h08 && st == 5'h10
		|-> cnt == T) else $error("turn-off delay length wrong");
	a_fall_len: assert property (prev_st == 5'h10 && st == 5'h00
		|-> cnt == T) else $error("fall length wrong");
	cover property (st == 5'h04);
	cover property (rd_valid);
	cover property (fault_present);
endmodule

bind prc_command_map prc_command_map_asserts #(
	.CYCLES_PER_MS(CYCLES_PER_MS)
) prc_command_map_asserts_inst (.core_clk, .rst, .rd_strobe, .rd_valid,
	.vout_flag_set, .iout_flag_set, .input_flag_set, .temp_flag_set,
	.cml_flag_set, .mfr_flag_set, .enable, .rail_on_delay, .rail_rising,
	.rail_on, .rail_off_delay, .rail_falling, .power_good, .fault_present);

// ==== test/prc_command_map_tb.sv ====
// self-checking bench for the command map and rail sequencer
// assumes the host model drives the command port; timing scaled to 8/ms
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
	n_fail++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module prc_command_map_tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic clear_faults = 1'b0;
	logic telemetry_load = 1'b0;
	logic enable = 1'b0;
	logic [7:0] fs [6] = '{default: 8'h00};
	logic [15:0] smp [5] = '{default: 16'h0000};
	logic [7:0] cmd_code;
	logic wr_strobe, rd_strobe, rd_valid, power_good, fault_present;
	logic [15:0] wr_data, rd_data;
	logic [4:0] rails;
	int n_fail = 0;
	int total_checks = 0;
	int n;
	always #4 core_clk = ~core_clk;
	prc_host_model prc_host_model_inst (.core_clk, .rd_data, .rd_valid,
		.cmd_code, .wr_strobe, .wr_data, .rd_strobe);
	prc_command_map #(.CYCLES_PER_MS(8)) prc_command_map_inst (.core_clk,
		.rst, .cmd_code, .wr_strobe, .wr_data, .rd_strobe, .rd_data,
		.rd_valid, .clear_faults, .vout_flag_set(fs[0]),
		.iout_flag_set(fs[1]), .input_flag_set(fs[2]),
		.temp_flag_set(fs[3]), .cml_flag_set(fs[4]), .mfr_flag_set(fs[5]),
		.telemetry_load, .vin_sample(smp[0]), .iin_sample(smp[1]),
		.vout_sample(smp[2]), .iout_sample(smp[3]), .temp_sample(smp[4]),
		.vin_uv_fault_strap(16'hc9f4), .vout_nominal_strap(16'h1000),
		.enable, .rail_on_delay(rails[0]), .rail_rising(rails[1]),
		.rail_on(rails[2]), .rail_off_delay(rails[3]),
		.rail_falling(rails[4]), .power_good, .fault_present);
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
		logic [15:0] got;
		prc_host_model_inst.rd(c, got);
		`CHK($sformatf("code %h", c), e, got)
	endtask
	task automatic pulse(ref logic s);
		@(posedge core_clk);
		#1 s = 1'b1;
		@(posedge core_clk);
		#1 s = 1'b0;
	endtask
	task automatic wait_rails(input logic [4:0] want);
		n = 0;
		while (rails !== want && n < 200) begin
			@(posedge core_clk);
			#1 n++;
		end
		if (n == 200) begin
			n_fail++;
			tally_and_finish();
		end
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		#1 rst = 1'b0;
		for (int i = 0; i < prc_pkg::NUM_RW; i++) begin
			if (i < 10 || i == 12 || i > 13)
				rd_chk(prc_pkg::RW_CODE[i], prc_pkg::RW_RESET[i]);
		end
		for (int i = 0; i < prc_pkg::NUM_ST; i++)
			rd_chk(prc_pkg::ST_CODE[i], 16'h0000);
		rd_chk(8'h79, 16'h0000);
		rd_chk(8'h78, 16'h0000);
		rd_chk(8'h59, 16'hc9f4);
		rd_chk(8'h58, 16'hca26);
		rd_chk(8'h5e, 16'h0e66);
		for (int i = 0; i < prc_pkg::NUM_RW; i++)
			prc_host_model_inst.wr(prc_pkg::RW_CODE[i],
				prc_pkg::RW_RESET[i] ^ 16'h5aa5);
		for (int i = 0; i < prc_pkg::NUM_RW; i++)
			rd_chk(prc_pkg::RW_CODE[i],
				(prc_pkg::RW_RESET[i] ^ 16'h5aa5) &
				(prc_pkg::RW_BYTE[i] ? 16'h00ff : 16'hffff));
		for (int i = 0; i < prc_pkg::NUM_RW; i++)
			prc_host_model_inst.wr(prc_pkg::RW_CODE[i], prc_pkg::RW_RESET[i]);
		prc_host_model_inst.wr(8'h88, 16'h1234);
		rd_chk(8'h88, 16'h0000);
		rd_chk(8'h4c, 16'h0000);
		rd_chk(8'h7e, 16'h0082);
		rd_chk(8'h78, 16'h0002);
		pulse(clear_faults);
		@(posedge core_clk);
		#1 fs = '{8'h01, 8'h02, 8'h04, 8'h40, 8'h00, 8'h01};
		@(posedge core_clk);
		#1 fs = '{default: 8'h00};
		rd_chk(8'h7a, 16'h0001);
		rd_chk(8'h7b, 16'h0002);
		rd_chk(8'h7c, 16'h0004);
		rd_chk(8'h7d, 16'h0040);
		rd_chk(8'h80, 16'h0001);
		rd_chk(8'h79, 16'hf005);
		rd_chk(8'h78, 16'h0005);
		`CHK("fault present", 1'b1, fault_present)
		pulse(clear_faults);
		rd_chk(8'h79, 16'h0000);
		`CHK("fault cleared", 1'b0, fault_present)
		smp = '{16'hd1a0, 16'hb2c0, 16'h1400, 16'hc3e8, 16'he0f0};
		pulse(telemetry_load);
		for (int i = 0; i < prc_pkg::NUM_TEL; i++)
			rd_chk(prc_pkg::TEL_CODE[i], smp[i]);
		prc_host_model_inst.wr(8'h8b, 16'hffff);
		rd_chk(8'h8b, smp[2]);
		rd_chk(8'h7e, 16'h0002);
		prc_host_model_inst.wr(8'h5e, 16'h1800);
		@(posedge core_clk);
		#1 enable = 1'b1;
		wait_rails(5'h04);
		`CHK("turn-on cycles", 81, n)
		repeat (2) @(posedge core_clk);
		#1;
		`CHK("good below threshold", 1'b0, power_good)
		prc_host_model_inst.wr(8'h5e, 16'h1000);
		repeat (2) @(posedge core_clk);
		#1;
		`CHK("good above threshold", 1'b1, power_good)
		@(posedge core_clk);
		#1 enable = 1'b0;
		wait_rails(5'h00);
		`CHK("turn-off cycles", 81, n)
		tally_and_finish();
	end
endmodule

// ==== test/prc_host_model.sv ====
// host side of the decoded command port: one access per task call
// assumes the bench calls wr and rd and owns the clock
`timescale 1ns/1ps
module prc_host_model (
	input wire logic core_clk,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid,
	output logic [7:0] cmd_code,
	output logic wr_strobe,
	output logic [15:0] wr_data,
	output logic rd_strobe
);
	initial begin
		cmd_code = 8'h00;
		wr_strobe = 1'b0;
		wr_data = 16'h0000;
		rd_strobe = 1'b0;
	end
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(posedge core_clk);
		#1;
		cmd_code = c;
		wr_data = d;
		wr_strobe = 1'b1;
		@(posedge core_clk);
		#1;
		wr_strobe = 1'b0;
		// released lines show garbage, not the last value
		cmd_code = ~c;
		wr_data = ~d;
	endtask
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		@(posedge core_clk);
		#1;
		cmd_code = c;
		rd_strobe = 1'b1;
		@(posedge core_clk);
		#1;
		rd_strobe = 1'b0;
		cmd_code = ~c;
		// answer stands one cycle only; a missing answer reads unknown
		d = rd_valid ? rd_data : 16'hxxxx;
	endtask
endmodule
